//--- rtl/ext_wr_clkgen.sv
/*
  Clock generator: derives processor, peripheral and clock output enables from the oscillator-rate clock.
  Assumes the system clock stands for the crystal input; slower rates are one-cycle enables.
*/
`timescale 1ns/1ps
module ext_wr_clkgen (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Derived clocks
  output logic cpu_en_o,
  output logic periph_en_o,
  output logic clk_pin_o
);
  logic [3:0] half_q;
  logic [3:0] per_q;

  // Half counter toggles the clock output; processor enable marks each fall of it; peripherals use a further divide.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      half_q <= 4'h0;
      cpu_en_o <= 1'b0;
      clk_pin_o <= 1'b0;
    end else begin
      cpu_en_o <= 1'b0;
      if (half_q == ext_wr_pkg::CLK_PIN_HALF_CNT) begin
        half_q <= 4'h0;
        clk_pin_o <= ~clk_pin_o;
        cpu_en_o <= clk_pin_o;
      end else begin
        half_q <= half_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      per_q <= 4'h0;
      periph_en_o <= 1'b0;
    end else begin
      periph_en_o <= 1'b0;
      if (cpu_en_o) begin
        if (per_q == ext_wr_pkg::PERIPH_DIV_CNT) begin
          per_q <= 4'h0;
          periph_en_o <= 1'b1;
        end else begin
          per_q <= per_q + 4'h1;
        end
      end
    end
  end

  a_cpu_en_fall: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cpu_en_o |-> $past(clk_pin_o) && !clk_pin_o) else $error("cpu enable not at clock output fall");
endmodule

//--- rtl/ext_wr_pkg.sv
/*
  Package for the external write strobe logic: configuration width and bit position, bus cycle phases, timing and reset values.
  Assumes a single 100 MHz system clock; no package imports anywhere.
*/
package ext_wr_pkg;
  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  // Clock output pin period; the processor enable follows each falling edge of that pin.
  localparam int CLK_PIN_PERIOD_NS = 20;
  localparam int CLK_PIN_HALF_CYC = (CLK_PIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CLK_PIN_HALF_CNT = 4'(CLK_PIN_HALF_CYC - 1);
  // Peripheral clock runs at a quarter of the processor clock rate.
  localparam logic [3:0] PERIPH_DIV_CNT = 4'h3;

  // ****************************************************************
  // Configuration
  // ****************************************************************
  localparam int CFG_WIDTH = 8;
  localparam int CFG_WR_MODE_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'hFF;

  // ****************************************************************
  // Bus cycle phases
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_DATA,
    PH_END
  } bus_phase_t;
endpackage

//--- rtl/ext_wr_strobe.sv
/*
  External write strobe logic: sequences an external bus cycle and drives read, write and high-byte pins.
  Assumes requests come from the processor on the same clock; ready comes from a pin and is synchronised.
*/
// Functional notes
// - Combined write strobe low only during external writes, never reads or internal accesses.
// - Config bit two high selects combined write, low selects low-byte write strobe.
// - Config bit two high selects high-byte enable, low selects high-byte write strobe.
// - In 16-bit cycles high-byte strobe asserts for high-byte and word writes.
// - In 8-bit cycles high-byte strobe asserts for every write.
// - In 16-bit cycles low-byte strobe asserts for low-byte and word writes.
// - In 8-bit cycles low-byte strobe asserts for every write.
// - Processor, peripheral and clock output derive from the crystal-rate clock.
// - Read strobe low only during external memory reads.
// - Ready low adds wait states to external cycles; ignored for internal accesses.
`timescale 1ns/1ps
module ext_wr_strobe (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Configuration
  input wire logic [7:0] chip_config_reg_zero_i,
  // Processor request
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_external_i,
  input wire logic req_bus16_i,
  input wire logic req_byte_i,
  input wire logic req_addr0_i,
  // Pins
  input wire logic ready_i,
  output logic low_byte_write_strobe_n_o,
  output logic high_byte_write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic clock_output_pin_o,
  // Status
  output logic busy_o,
  output logic done_o,
  output logic cpu_en_o,
  output logic periph_en_o
);
  // ****************************************************************
  // Clock generation
  // ****************************************************************
  logic cpu_en;
  logic periph_en;
  logic clk_pin;

  ext_wr_clkgen u_clkgen (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .cpu_en_o(cpu_en),
    .periph_en_o(periph_en),
    .clk_pin_o(clk_pin)
  );

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      clock_output_pin_o <= 1'b0;
      cpu_en_o <= 1'b0;
      periph_en_o <= 1'b0;
    end else begin
      clock_output_pin_o <= clk_pin;
      cpu_en_o <= cpu_en;
      periph_en_o <= periph_en;
    end
  end

  // ****************************************************************
  // Ready synchroniser
  // ****************************************************************
  logic rdy_meta_q;
  logic rdy_sync_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdy_meta_q <= 1'b1;
      rdy_sync_q <= 1'b1;
    end else begin
      rdy_meta_q <= ready_i;
      rdy_sync_q <= rdy_meta_q;
    end
  end

  // ****************************************************************
  // Request capture
  // ****************************************************************
  logic wr_q;
  logic ext_q;
  logic b16_q;
  logic byte_q;
  logic a0_q;
  logic cmode_q;
  ext_wr_pkg::bus_phase_t ph_q;

  // The mode bit is frozen per cycle so a configuration change cannot glitch a live strobe.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_q <= 1'b0;
      ext_q <= 1'b0;
      b16_q <= 1'b0;
      byte_q <= 1'b0;
      a0_q <= 1'b0;
      cmode_q <= ext_wr_pkg::CFG_RESET[ext_wr_pkg::CFG_WR_MODE_BIT];
    end else if (ph_q == ext_wr_pkg::PH_IDLE && req_i) begin
      wr_q <= req_write_i;
      ext_q <= req_external_i;
      b16_q <= req_bus16_i;
      byte_q <= req_byte_i;
      a0_q <= req_addr0_i;
      cmode_q <= chip_config_reg_zero_i[ext_wr_pkg::CFG_WR_MODE_BIT];
    end
  end

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ph_q <= ext_wr_pkg::PH_IDLE;
    end else begin
      unique case (ph_q)
        ext_wr_pkg::PH_IDLE: begin
          if (req_i) begin
            ph_q <= ext_wr_pkg::PH_ADDR;
          end
        end
        ext_wr_pkg::PH_ADDR: begin
          ph_q <= ext_wr_pkg::PH_DATA;
        end
        ext_wr_pkg::PH_DATA: begin
          if (!ext_q || rdy_sync_q) begin
            ph_q <= ext_wr_pkg::PH_END;
          end
        end
        ext_wr_pkg::PH_END: begin
          ph_q <= ext_wr_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Strobe decode
  // ****************************************************************
  // Returns {high lane, low lane} active for the captured cycle.
  function automatic logic [1:0] lanes(input logic b16, input logic byte_op, input logic a0);
    logic [1:0] l;
    l = 2'b11;
    if (!b16) begin
      l = 2'b11;
    end else if (byte_op) begin
      l = a0 ? 2'b10 : 2'b01;
    end
    return l;
  endfunction

  logic [1:0] ln;
  logic strobe_ph;
  logic ext_wr;
  logic ext_rd;
  assign ln = lanes(b16_q, byte_q, a0_q);
  assign strobe_ph = (ph_q == ext_wr_pkg::PH_DATA);
  assign ext_wr = strobe_ph && ext_q && wr_q;
  assign ext_rd = strobe_ph && ext_q && !wr_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      low_byte_write_strobe_n_o <= 1'b1;
      high_byte_write_strobe_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      read_strobe_n_o <= !ext_rd;
      if (cmode_q) begin
        low_byte_write_strobe_n_o <= !ext_wr;
        high_byte_write_strobe_n_o <= !(strobe_ph && ext_q && ln[1]);
      end else begin
        low_byte_write_strobe_n_o <= !(ext_wr && ln[0]);
        high_byte_write_strobe_n_o <= !(ext_wr && ln[1]);
      end
      busy_o <= (ph_q != ext_wr_pkg::PH_IDLE);
      done_o <= (ph_q == ext_wr_pkg::PH_END);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_ext_write;
    strobe_ph && ext_q && wr_q;
  endsequence

  sequence s_ext_read;
    strobe_ph && ext_q && !wr_q;
  endsequence

  a_wr_only_ext: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmode_q && !ext_wr) |=> low_byte_write_strobe_n_o) else $error("combined write outside write");
  a_wr_combined: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ext_write ##0 cmode_q |=> !low_byte_write_strobe_n_o) else $error("combined write missing");
  a_hi_en_lane: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (strobe_ph && ext_q && cmode_q && ln[1]) |=> !high_byte_write_strobe_n_o) else $error("high enable missing");
  a_hi_en_quiet: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (strobe_ph && cmode_q && b16_q && byte_q && !a0_q) |=> high_byte_write_strobe_n_o)
    else $error("high enable on low byte");
  a_hi_wr_16bit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ext_write ##0 (!cmode_q && b16_q) |=> high_byte_write_strobe_n_o == !(!byte_q || a0_q))
    else $error("high write strobe wrong in 16-bit cycle");
  a_hi_wr_8bit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ext_write ##0 (!cmode_q && !b16_q) |=> !high_byte_write_strobe_n_o) else $error("high write missing 8-bit");
  a_lo_wr_16bit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ext_write ##0 (!cmode_q && b16_q) |=> low_byte_write_strobe_n_o == !(!byte_q || !a0_q))
    else $error("low write strobe wrong in 16-bit cycle");
  a_lo_wr_8bit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ext_write ##0 (!cmode_q && !b16_q) |=> !low_byte_write_strobe_n_o) else $error("low write missing 8-bit");
  a_rd_only_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !read_strobe_n_o |-> $past(ext_rd)) else $error("read strobe outside external read");
  a_rd_on_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ext_read |=> !read_strobe_n_o) else $error("read strobe missing");
  a_wait_ready: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (strobe_ph && ext_q && !rdy_sync_q) |=> strobe_ph) else $error("wait state not inserted");
  a_internal_nowait: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (strobe_ph && !ext_q) |=> ph_q == ext_wr_pkg::PH_END ##1 ph_q == ext_wr_pkg::PH_IDLE)
    else $error("internal access stalled");
endmodule

//--- tb/ext_wr_mem_partner.sv
/*
  Memory-side partner for the write strobe block: answers on the ready pin, promptly or with wait states.
  Assumes the device's active-low strobes and the one system clock.
*/
`timescale 1ns/1ps
module ext_wr_mem_partner (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Mode and strobes
  input wire logic slow_i,
  input wire logic [2:0] strobe_n_i,
  // Ready pin
  output logic ready_o
);
  logic [3:0] low_cnt_q;

  // Slow memory holds ready low, even between cycles, until a strobe has been low for two cycles.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || (&strobe_n_i)) begin
      low_cnt_q <= 4'h0;
    end else if (low_cnt_q != 4'hF) begin
      low_cnt_q <= low_cnt_q + 4'h1;
    end
  end

  assign ready_o = !slow_i || (low_cnt_q >= 4'h2);
endmodule

//--- tb/ext_wr_strobe_tb.sv
/*
  Self-checking bench for the write strobe block, with a reference model of the strobe selection.
  Assumes the memory partner model on the ready pin and a 100 MHz system clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ext_wr_strobe_tb;
  logic clk_sys_i;
  logic sys_rst_i;
  logic [7:0] cfg;
  logic req_i, wr, ext, b16, byt, a0, slow, ready;
  logic lo_n, hi_n, rd_n, clko, busy, done, cpu_en, per_en;
  int err_total = 0;
  int checks_done = 0;

  ext_wr_strobe u_ext_wr_strobe (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .chip_config_reg_zero_i(cfg),
    .req_i(req_i), .req_write_i(wr), .req_external_i(ext), .req_bus16_i(b16), .req_byte_i(byt),
    .req_addr0_i(a0), .ready_i(ready), .low_byte_write_strobe_n_o(lo_n), .high_byte_write_strobe_n_o(hi_n),
    .read_strobe_n_o(rd_n), .clock_output_pin_o(clko), .busy_o(busy), .done_o(done), .cpu_en_o(cpu_en),
    .periph_en_o(per_en));

  ext_wr_mem_partner u_ext_wr_mem_partner (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
    .strobe_n_i({lo_n, hi_n, rd_n}), .ready_o(ready));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // A strobe that should fire lasts one cycle, or longer when the memory asks for waits.
  function automatic logic cnt_ok(int n, logic ex, logic s);
    return ex ? (s ? n > 1 : n == 1) : n == 0;
  endfunction

  task automatic run(input logic m, w, e, b, y, a, s);
    int lat, nl, nh, nr, nb;
    logic el, eh, er;
    lat = 0;
    nl = 0;
    nh = 0;
    nr = 0;
    nb = 0;
    slow <= s;
    repeat (2) @(posedge clk_sys_i);
    cfg <= {5'($urandom), m, 2'($urandom)};
    {wr, ext, b16, byt, a0} <= {w, e, b, y, a};
    req_i <= 1'b1;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    while (done !== 1'b1 && lat < 40) begin
      @(posedge clk_sys_i);
      #1;
      lat++;
      nl += (lo_n === 1'b0);
      nh += (hi_n === 1'b0);
      nr += (rd_n === 1'b0);
      nb += (busy === 1'b1);
    end
    if (lat == 40) begin
      err_total++;
      give_verdict();
    end
    el = e && w && (m || !b || !y || !a);
    eh = e && (m || w) && (!b || !y || a);
    er = e && !w;
    `CHK(cnt_ok(nl, el, s), 1'b1)
    `CHK(cnt_ok(nh, eh, s), 1'b1)
    `CHK(cnt_ok(nr, er, s), 1'b1)
    // The done pulse shows three edges after the take edge when no wait state is added.
    `CHK((s && e) ? lat > 3 : lat == 3, 1'b1)
    `CHK(nb, lat)
  endtask

  task automatic clocks();
    int tg, nc, np, per;
    logic prev;
    tg = 0;
    nc = 0;
    np = 0;
    per = 2 * (int'(ext_wr_pkg::CLK_PIN_HALF_CNT) + 1);
    // The peripheral divider needs a few processor enables after reset before its rate is steady.
    repeat (16) @(posedge clk_sys_i);
    #1;
    prev = clko;
    repeat (64) begin
      @(posedge clk_sys_i);
      #1;
      tg += (clko !== prev);
      prev = clko;
      nc += (cpu_en === 1'b1);
      np += (per_en === 1'b1);
    end
    `CHK(tg, 128 / per)
    `CHK(nc, 64 / per)
    `CHK(np, 64 / (per * (int'(ext_wr_pkg::PERIPH_DIV_CNT) + 1)))
  endtask

  initial begin
    void'($urandom(32'h2422bb34));
    sys_rst_i <= 1'b1;
    cfg <= 8'h00;
    {req_i, wr, ext, b16, byt, a0, slow} <= 7'h00;
    repeat (7) @(posedge clk_sys_i);
    #1;
    `CHK({lo_n, hi_n, rd_n, busy, done}, 5'h1C)
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    clocks();
    $display("test clocks done");
    for (int i = 0; i < 128; i++) begin
      run(i[5], i[4], i[3], i[2], i[1], i[0], i[6]);
    end
    $display("test all codes, prompt and slow, done");
    for (int i = 0; i < 60; i++) begin
      run(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    end
    $display("test random done");
    give_verdict();
  end
endmodule
